// >>> inc/ccb_pkg.sv
`default_nettype none

package ccb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // byte offsets
    localparam logic [7:0] CCB_OFS_STRAP = 8'h05;
    localparam logic [7:0] CCB_OFS_IDENT = 8'h06;
    localparam logic [7:0] CCB_OFS_RSVD = 8'h07;
    localparam logic [7:0] CCB_OFS_WDOG = 8'h08;
    localparam logic [7:0] CCB_OFS_DRIVE = 8'h09;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CCB_STRAP_W = 5;
    localparam int CCB_STRAP_LSB = 3;
    localparam int CCB_BYPASS_BIT = 2;
    localparam int CCB_SHARED_BIT = 1;
    localparam int CCB_DUAL_BIT = 0;
    localparam int CCB_REV_LSB = 4;
    localparam int CCB_WD_CNT_W = 5;
    localparam int CCB_WD_CNT_LSB = 1;
    localparam int CCB_WD_TICK_BIT = 0;
    localparam int CCB_USB_DRV_BIT = 7;
    localparam int CCB_SLOT_DRV_BIT = 6;
    localparam int CCB_HUB_DRV_BIT = 5;
    localparam int CCB_WD_RST_EN_BIT = 4;
    localparam int CCB_FC_RST_EN_BIT = 3;
    localparam int CCB_WD_FLAG_BIT = 2;
    localparam int CCB_WD_RUN_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [4:0] CCB_WD_COUNT_RST = 5'h1F;
    localparam logic [3:0] CCB_REV_CODE_RST = 4'h0;
    localparam logic [7:0] CCB_BYTE_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam longint CCB_CLK_PERIOD_PS = 4000;
    localparam longint CCB_SHORT_TICK_MS = 150;
    localparam longint CCB_LONG_TICK_MS = 2500;
    localparam longint CCB_PS_PER_MS = 1000000000;
    localparam longint CCB_SHORT_TICK_CYC = (CCB_SHORT_TICK_MS * CCB_PS_PER_MS) / CCB_CLK_PERIOD_PS;
    localparam longint CCB_LONG_TICK_CYC = (CCB_LONG_TICK_MS * CCB_PS_PER_MS) / CCB_CLK_PERIOD_PS;

    typedef enum logic [2:0]
    {
        CCB_WD_IDLE = 3'b001,
        CCB_WD_COUNT = 3'b010,
        CCB_WD_DONE = 3'b100
    } ccb_wd_state_t;

endpackage : ccb_pkg

`default_nettype wire

// >>> inc/ccb_ctl_if.sv
`default_nettype none

interface ccb_ctl_if;
    import ccb_pkg::*;
    logic tick;
    logic tick_clear;
    logic tick_pick;
    logic [CCB_STRAP_W-1:0] strap_value;
    logic strap_valid;

    modport tick_src (output tick, input tick_clear, input tick_pick);
    modport strap_src (output strap_value, output strap_valid);
    modport core (input tick, input strap_value, input strap_valid,
                  output tick_clear, output tick_pick);
endinterface : ccb_ctl_if

`default_nettype wire

// >>> core/ccb_tick_gen.sv
`default_nettype none

module ccb_tick_gen
    import ccb_pkg::*;
#(
    parameter int unsigned SHORT_CYC = 32'(CCB_SHORT_TICK_CYC),
    parameter int unsigned LONG_CYC = 32'(CCB_LONG_TICK_CYC)
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    ccb_ctl_if.tick_src ctl
);

    // a one-cycle period would tick every cycle and leave no idle cycle between ticks
    if (SHORT_CYC < 2 || LONG_CYC < 2)
    begin : g_bad_period
        $error("tick periods must be at least two cycles");
    end

    logic [31:0] cnt;
    logic [31:0] period;
    logic last_pick;
    logic pick_moved;

    // one tick per selected prescaler period
    assign period = ctl.tick_pick ? LONG_CYC : SHORT_CYC;
    // a new pick restarts the period, so no step comes out short
    assign pick_moved = ctl.tick_pick != last_pick;
    assign ctl.tick = (cnt >= period - 32'h00000001) && !ctl.tick_clear && !pick_moved;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cnt <= 32'h00000000;
        else if (ctl.tick_clear || ctl.tick || pick_moved)
            cnt <= 32'h00000000;
        else
            cnt <= cnt + 32'h00000001;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            last_pick <= 1'b0;
        else
            last_pick <= ctl.tick_pick;
    end

    a_tick_spacing: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctl.tick |=> !ctl.tick)
        else $error("ticks came back to back");
    a_tick_period: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ctl.tick && !ctl.tick_pick) |-> cnt == SHORT_CYC - 32'h00000001)
        else $error("short tick at wrong count");

endmodule : ccb_tick_gen

`default_nettype wire

// >>> core/ccb_strap_latch.sv
`default_nettype none

module ccb_strap_latch
    import ccb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [CCB_STRAP_W-1:0] freq_strap_pins,
    ccb_ctl_if.strap_src ctl
);

    logic captured;
    logic [CCB_STRAP_W-1:0] value;

    // straps are sampled once, at the first edge after reset release
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            captured <= 1'b0;
            value <= 5'h00;
        end
        else if (!captured)
        begin
            captured <= 1'b1;
            value <= freq_strap_pins;
        end
    end

    assign ctl.strap_value = value;
    assign ctl.strap_valid = captured;

    a_strap_frozen: assert property (@(posedge ref_clk) disable iff (!nrst)
        captured |=> $stable(value))
        else $error("strap value moved after capture");

endmodule : ccb_strap_latch

`default_nettype wire

// >>> core/ccb_top.sv
// What this block does
// - strap values latched at power-up read in bits 7..3, read-only.
// - bypass bit 0 uses straps, 1 uses software code; resets 0.
// - bit 1 picks shared output rate, bit 0 dual output rate; reset 0.
// - identification byte: revision in 7..4, fixed maker code in 3..0.
// - watchdog byte 5..1 hold count, resets all ones; 7..6 reserved.
// - count step is one prescaler period, short or long range.
// - watchdog byte bit 0 picks 150 ms or 2.5 s tick; reset 0.
// - at count zero set expired flag; reset pulse only if enabled.
// - drive byte bit 4 enables reset pulse on expiry; reset 0.
// - drive byte bits 7..5 boost drive of three output groups; reset 0.
// - with run set, count starts on frequency change; run 0 stops, reloads.
// - expired flag reads 1 after expiry; write 1 clears, 0 ignored.
`default_nettype none

module ccb_top
    import ccb_pkg::*;
#(
    parameter int unsigned SHORT_TICK_CYCLES = 32'(CCB_SHORT_TICK_CYC),
    parameter int unsigned LONG_TICK_CYCLES = 32'(CCB_LONG_TICK_CYC),
    parameter logic [3:0] REVISION_CODE = CCB_REV_CODE_RST,
    // arbitrary neutral value
    parameter logic [3:0] MAKER_CODE = 4'h5
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [4:0] freq_strap_pins,
    input wire logic [4:0] sw_freq_code,
    input wire logic freq_change,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [4:0] active_freq_code,
    output logic strap_bypass,
    output logic shared_output_rate_pick,
    output logic dual_rate_output_pick,
    output logic usb_group_drive_boost,
    output logic slot_bus_group_drive_boost,
    output logic hub_group_drive_boost,
    output logic freq_change_reset_enable,
    output logic wdog_expired_flag,
    output logic wdog_counting,
    output logic freq_locked,
    output logic sys_reset_pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    ccb_ctl_if ctl ();

    ccb_tick_gen #(
        .SHORT_CYC(SHORT_TICK_CYCLES),
        .LONG_CYC(LONG_TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ctl(ctl.tick_src)
    );

    ccb_strap_latch u_strap (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .freq_strap_pins(freq_strap_pins),
        .ctl(ctl.strap_src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic wr_strap;
    logic wr_wdog;
    logic wr_drive;
    logic [4:0] wdog_timeout_count;
    logic wdog_tick_pick;
    logic wdog_reset_enable;
    logic wdog_run;
    logic bypass_toggle;
    logic run_stop;
    logic flag_clear;
    ccb_wd_state_t state;
    ccb_wd_state_t next_state;
    logic [4:0] wd_count;
    logic start;
    logic expire_now;

    assign wr_strap = reg_wr && reg_addr == CCB_OFS_STRAP;
    assign wr_wdog = reg_wr && reg_addr == CCB_OFS_WDOG;
    assign wr_drive = reg_wr && reg_addr == CCB_OFS_DRIVE;

    // locked after an expiry: frequency source may not change until run is cleared
    assign bypass_toggle = wr_strap && !freq_locked
        && reg_wdata[CCB_BYPASS_BIT] != strap_bypass;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            strap_bypass <= 1'b0;
        else if (wr_strap && !freq_locked)
            strap_bypass <= reg_wdata[CCB_BYPASS_BIT];
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shared_output_rate_pick <= 1'b0;
            dual_rate_output_pick <= 1'b0;
        end
        else if (wr_strap)
        begin
            shared_output_rate_pick <= reg_wdata[CCB_SHARED_BIT];
            dual_rate_output_pick <= reg_wdata[CCB_DUAL_BIT];
        end
    end

    // latched strap values picked unless the bypass is set
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            active_freq_code <= 5'h00;
        else
            active_freq_code <= strap_bypass ? sw_freq_code : ctl.strap_value;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wdog_timeout_count <= CCB_WD_COUNT_RST;
            wdog_tick_pick <= 1'b0;
        end
        else if (wr_wdog)
        begin
            wdog_timeout_count <= reg_wdata[CCB_WD_CNT_LSB +: CCB_WD_CNT_W];
            wdog_tick_pick <= reg_wdata[CCB_WD_TICK_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            usb_group_drive_boost <= 1'b0;
            slot_bus_group_drive_boost <= 1'b0;
            hub_group_drive_boost <= 1'b0;
            wdog_reset_enable <= 1'b0;
            freq_change_reset_enable <= 1'b0;
            wdog_run <= 1'b0;
        end
        else if (wr_drive)
        begin
            usb_group_drive_boost <= reg_wdata[CCB_USB_DRV_BIT];
            slot_bus_group_drive_boost <= reg_wdata[CCB_SLOT_DRV_BIT];
            hub_group_drive_boost <= reg_wdata[CCB_HUB_DRV_BIT];
            wdog_reset_enable <= reg_wdata[CCB_WD_RST_EN_BIT];
            freq_change_reset_enable <= reg_wdata[CCB_FC_RST_EN_BIT];
            wdog_run <= reg_wdata[CCB_WD_RUN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog

    assign run_stop = wr_drive && !reg_wdata[CCB_WD_RUN_BIT];
    // a new frequency change while counting restarts from the stored count
    assign start = wdog_run && (freq_change || bypass_toggle);
    assign expire_now = state == CCB_WD_COUNT && wd_count == 5'h00;
    assign flag_clear = wr_drive && reg_wdata[CCB_WD_FLAG_BIT];
    assign ctl.tick_pick = wdog_tick_pick;
    assign ctl.tick_clear = start;

    always_comb
    begin
        next_state = state;
        case (state)
            CCB_WD_IDLE:
                if (start)
                    next_state = CCB_WD_COUNT;
            CCB_WD_COUNT:
                if (expire_now)
                    next_state = CCB_WD_DONE;
            CCB_WD_DONE:
                next_state = CCB_WD_DONE;
            default:
                next_state = CCB_WD_IDLE;
        endcase
        if (run_stop)
            next_state = CCB_WD_IDLE;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            state <= CCB_WD_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            wd_count <= CCB_WD_COUNT_RST;
        else if (run_stop || state == CCB_WD_IDLE && !start)
            wd_count <= wdog_timeout_count;
        else if (start && state != CCB_WD_DONE)
            wd_count <= wdog_timeout_count;
        else if (state == CCB_WD_COUNT && ctl.tick && wd_count != 5'h00)
            wd_count <= wd_count - 5'h01;
    end

    // set beats clear when both land in one cycle
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            wdog_expired_flag <= 1'b0;
        else if (expire_now)
            wdog_expired_flag <= 1'b1;
        else if (flag_clear)
            wdog_expired_flag <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sys_reset_pulse <= 1'b0;
        else
            sys_reset_pulse <= expire_now && wdog_reset_enable;
    end

    assign wdog_counting = state == CCB_WD_COUNT;
    assign freq_locked = state == CCB_WD_DONE;

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = CCB_BYTE_ZERO;
        case (reg_addr)
            CCB_OFS_STRAP:
            begin
                next_rdata[CCB_STRAP_LSB +: CCB_STRAP_W] = ctl.strap_value;
                next_rdata[CCB_BYPASS_BIT] = strap_bypass;
                next_rdata[CCB_SHARED_BIT] = shared_output_rate_pick;
                next_rdata[CCB_DUAL_BIT] = dual_rate_output_pick;
            end
            CCB_OFS_IDENT:
            begin
                next_rdata[CCB_REV_LSB +: 4] = REVISION_CODE;
                next_rdata[3:0] = MAKER_CODE;
            end
            CCB_OFS_WDOG:
            begin
                next_rdata[CCB_WD_CNT_LSB +: CCB_WD_CNT_W] = wdog_timeout_count;
                next_rdata[CCB_WD_TICK_BIT] = wdog_tick_pick;
            end
            CCB_OFS_DRIVE:
            begin
                next_rdata[CCB_USB_DRV_BIT] = usb_group_drive_boost;
                next_rdata[CCB_SLOT_DRV_BIT] = slot_bus_group_drive_boost;
                next_rdata[CCB_HUB_DRV_BIT] = hub_group_drive_boost;
                next_rdata[CCB_WD_RST_EN_BIT] = wdog_reset_enable;
                next_rdata[CCB_FC_RST_EN_BIT] = freq_change_reset_enable;
                next_rdata[CCB_WD_FLAG_BIT] = wdog_expired_flag;
                next_rdata[CCB_WD_RUN_BIT] = wdog_run;
            end
            default:
                next_rdata = CCB_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata <= CCB_BYTE_ZERO;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_write(logic [7:0] ofs);
        reg_wr && reg_addr == ofs;
    endsequence

    sequence s_read(logic [7:0] ofs);
        reg_rd && reg_addr == ofs;
    endsequence

    a_strap_readback: assert property (ctl.strap_valid ##0 s_read(CCB_OFS_STRAP) ##1 1'b1
        |-> reg_rdata[7:3] == ctl.strap_value)
        else $error("strap readback wrong");
    a_bypass_source: assert property ((wr_strap && !freq_locked
        && reg_wdata[CCB_BYPASS_BIT]) ##1 1'b1
        |=> active_freq_code == $past(sw_freq_code))
        else $error("bypass did not pick software code");
    a_rate_picks: assert property (s_write(CCB_OFS_STRAP)
        |=> shared_output_rate_pick == $past(reg_wdata[1])
        && dual_rate_output_pick == $past(reg_wdata[0]))
        else $error("rate pick not stored");
    a_maker_fixed: assert property (s_read(CCB_OFS_IDENT)
        |=> reg_rvalid && reg_rdata[3:0] == MAKER_CODE)
        else $error("maker code altered");
    a_wdog_reserved: assert property (s_read(CCB_OFS_WDOG)
        |=> reg_rdata[7:6] == 2'h0)
        else $error("reserved watchdog bits set");
    a_expire_flag: assert property (expire_now
        |=> wdog_expired_flag && freq_locked == !$past(run_stop)
        && sys_reset_pulse == $past(wdog_reset_enable))
        else $error("expiry effects wrong");
    a_reset_gated: assert property (!wdog_reset_enable |=> !sys_reset_pulse)
        else $error("reset pulse while disabled");
    a_drive_bits: assert property (s_write(CCB_OFS_DRIVE)
        |=> hub_group_drive_boost == $past(reg_wdata[5])
        && slot_bus_group_drive_boost == $past(reg_wdata[6])
        && usb_group_drive_boost == $past(reg_wdata[7]))
        else $error("drive bits not stored");
    a_run_stop: assert property (run_stop ##1 !reg_wr
        |-> state == CCB_WD_IDLE ##1 wd_count == wdog_timeout_count)
        else $error("stop did not reload");
    a_flag_clear: assert property ((flag_clear && !expire_now)
        |=> !wdog_expired_flag)
        else $error("flag not cleared");
    a_count_step: assert property ((state == CCB_WD_COUNT && ctl.tick
        && wd_count != 5'h00 && !start && !run_stop)
        |=> wd_count == $past(wd_count) - 5'h01)
        else $error("count did not step");

endmodule : ccb_top

`default_nettype wire

// >>> tb/ccb_host_model.sv
`default_nettype none

module ccb_host_model
    import ccb_pkg::*;
(
    input wire logic ref_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // released lines show the inverse so a stale value can never look valid
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        // let the write land before the caller looks at any output
        #1;
    endtask : write_byte

    // status clear is a write of one to the flag, with run kept as given
    task automatic clear_flag(input logic [7:0] keep);
        write_byte(CCB_OFS_DRIVE, keep | 8'h04);
    endtask : clear_flag

    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        n = 0;
        #1;
        while (reg_rvalid !== 1'b1 && n < 4)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask : read_byte
endmodule : ccb_host_model

`default_nettype wire

// >>> tb/tb_ccb_top.sv
`default_nettype none

module tb_ccb_top
    import ccb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SHORT_P = 4;
    localparam int LONG_P = 7;
    localparam logic [3:0] REV = 4'h0;
    // arbitrary neutral value
    localparam logic [3:0] MAKER = 4'h5;
    localparam logic [4:0] STRAPS = 5'h13;
    localparam logic [4:0] SW_CODE = 5'h0A;

    logic ref_clk, nrst, freq_change, reg_wr, reg_rd, reg_rvalid;
    logic [4:0] freq_strap_pins, sw_freq_code, active_freq_code;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic strap_bypass, shared_pick, dual_pick, usb_drv, slot_drv, hub_drv;
    logic fc_rst_en, wdog_expired_flag, wdog_counting, freq_locked, sys_reset_pulse;
    int failures = 0;
    int n_tests = 0;
    int pulses = 0;
    int n;

    ccb_top #(.SHORT_TICK_CYCLES(SHORT_P), .LONG_TICK_CYCLES(LONG_P),
        .REVISION_CODE(REV), .MAKER_CODE(MAKER)) u_ccb_top (
        .ref_clk(ref_clk), .nrst(nrst), .freq_strap_pins(freq_strap_pins),
        .sw_freq_code(sw_freq_code), .freq_change(freq_change), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .active_freq_code(active_freq_code), .strap_bypass(strap_bypass),
        .shared_output_rate_pick(shared_pick), .dual_rate_output_pick(dual_pick),
        .usb_group_drive_boost(usb_drv), .slot_bus_group_drive_boost(slot_drv),
        .hub_group_drive_boost(hub_drv), .freq_change_reset_enable(fc_rst_en),
        .wdog_expired_flag(wdog_expired_flag), .wdog_counting(wdog_counting),
        .freq_locked(freq_locked), .sys_reset_pulse(sys_reset_pulse));

    ccb_host_model u_ccb_host_model (
        .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if (sys_reset_pulse === 1'b1)
            pulses++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_ccb_host_model.read_byte(a, rd);
        check(rd, exp);
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_ccb_host_model.write_byte(a, d);
    endtask : wr

    // start edge is the one after the raise; n counts cycles from it
    task automatic run_to_expiry();
        @(posedge ref_clk);
        freq_change <= 1'b1;
        @(posedge ref_clk);
        freq_change <= 1'b0;
        n = 0;
        while (wdog_expired_flag !== 1'b1 && n < 1000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask : run_to_expiry

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #40000;
        failures++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        freq_change = 1'b0;
        freq_strap_pins = STRAPS;
        sw_freq_code = SW_CODE;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);

        rd_chk(CCB_OFS_STRAP, {STRAPS, 3'h0});
        rd_chk(CCB_OFS_IDENT, {REV, MAKER});
        rd_chk(CCB_OFS_RSVD, 8'h00);
        rd_chk(CCB_OFS_WDOG, 8'h3E);
        rd_chk(CCB_OFS_DRIVE, 8'h00);
        rd_chk(8'h20, 8'h00);
        check({3'h0, active_freq_code}, {3'h0, STRAPS});
        $display("test reset values done");

        // straps are latched once: later pin moves must not show
        @(posedge ref_clk);
        freq_strap_pins <= ~STRAPS;
        wr(CCB_OFS_STRAP, 8'hFF);
        rd_chk(CCB_OFS_STRAP, {STRAPS, 3'h7});
        check({5'h0, strap_bypass, shared_pick, dual_pick}, 8'h07);
        check({3'h0, active_freq_code}, {3'h0, SW_CODE});
        wr(CCB_OFS_IDENT, 8'hFF);
        rd_chk(CCB_OFS_IDENT, {REV, MAKER});
        wr(CCB_OFS_RSVD, 8'hFF);
        rd_chk(CCB_OFS_RSVD, 8'h00);
        wr(CCB_OFS_WDOG, 8'hFF);
        rd_chk(CCB_OFS_WDOG, 8'h3F);
        // usb, slot bus and hub groups boosted as if each fed two loads
        wr(CCB_OFS_DRIVE, 8'hE8);
        rd_chk(CCB_OFS_DRIVE, 8'hE8);
        check({4'h0, usb_drv, slot_drv, hub_drv, fc_rst_en}, 8'h0F);
        wr(8'h20, 8'hFF);
        rd_chk(8'h20, 8'h00);
        wr(CCB_OFS_STRAP, 8'h00);
        wr(CCB_OFS_DRIVE, 8'h00);
        check({5'h0, strap_bypass, shared_pick, dual_pick}, 8'h00);
        $display("test register access done");

        wr(CCB_OFS_WDOG, 8'h04);
        wr(CCB_OFS_DRIVE, 8'h12);
        run_to_expiry();
        check(8'(n >= 2 * SHORT_P && n <= 2 * SHORT_P + 3), 8'h01);
        repeat (2) @(posedge ref_clk);
        #1;
        check({5'h0, wdog_expired_flag, freq_locked, wdog_counting}, 8'h06);
        check(8'(pulses), 8'h01);
        rd_chk(CCB_OFS_DRIVE, 8'h16);
        wr(CCB_OFS_STRAP, 8'h04);
        check({7'h0, strap_bypass}, 8'h00);
        wr(CCB_OFS_DRIVE, 8'h12);
        check({7'h0, wdog_expired_flag}, 8'h01);
        u_ccb_host_model.clear_flag(8'h10);
        check({6'h0, wdog_expired_flag, freq_locked}, 8'h00);
        rd_chk(CCB_OFS_DRIVE, 8'h10);
        $display("test short expiry with reset done");

        wr(CCB_OFS_WDOG, 8'h03);
        wr(CCB_OFS_DRIVE, 8'h02);
        run_to_expiry();
        check(8'(n >= LONG_P && n <= LONG_P + 3), 8'h01);
        repeat (3) @(posedge ref_clk);
        check(8'(pulses), 8'h01);
        u_ccb_host_model.clear_flag(8'h00);
        check({6'h0, wdog_expired_flag, freq_locked}, 8'h00);
        $display("test long expiry without reset done");

        wr(CCB_OFS_WDOG, 8'h3E);
        wr(CCB_OFS_DRIVE, 8'h02);
        @(posedge ref_clk);
        freq_change <= 1'b1;
        @(posedge ref_clk);
        freq_change <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check({7'h0, wdog_counting}, 8'h01);
        wr(CCB_OFS_DRIVE, 8'h00);
        #1;
        check({7'h0, wdog_counting}, 8'h00);
        // full count of 31 short ticks fits well inside this wait
        repeat (300) @(posedge ref_clk);
        check({7'h0, wdog_expired_flag}, 8'h00);
        rd_chk(CCB_OFS_WDOG, 8'h3E);
        // a write that flips the bypass counts as a frequency change
        wr(CCB_OFS_DRIVE, 8'h02);
        wr(CCB_OFS_STRAP, 8'h04);
        check({6'h0, strap_bypass, wdog_counting}, 8'h03);
        wr(CCB_OFS_DRIVE, 8'h00);
        check({7'h0, wdog_counting}, 8'h00);
        $display("test stop and reload done");

        tally_and_finish();
    end
endmodule : tb_ccb_top

`default_nettype wire
